// ===== rtl/sdcc_core.sv
// sdram command decoder, bank state, burst engine, clock enable handling and register slave
`timescale 1ns/10ps
`include "sdcc_consts.svh"
module sdcc_core (
   input wire logic clock_in, // 40 MHz system clock
   input wire logic nrst_in, // synchronous reset, active low
   input wire logic cke_in, // clock enable pin
   input wire logic cs_n_in, // chip select pin, active low
   input wire logic ras_n_in, // row strobe pin, active low
   input wire logic cas_n_in, // column strobe pin, active low
   input wire logic we_n_in, // write enable pin, active low
   input wire logic bank_sel_0_in, // bank select bit 0
   input wire logic bank_sel_1_in, // bank select bit 1
   input wire logic [`SDCC_ADDR_W-1:0] addr_in, // address pins, bit 10 is auto_precharge_addr_bit
   input wire logic [3:0] avs_address_in, // register byte address
   input wire logic avs_read_in, // register read request
   input wire logic avs_write_in, // register write request
   input wire logic [31:0] avs_writedata_in, // register write data
   input wire logic [3:0] avs_byteenable_in, // register byte lanes
   output logic [31:0] avs_readdata_out, // register read data
   output logic avs_waitrequest_out, // register bus stall
   output logic rd_strobe_out, // read beat on the data pins
   output logic wr_strobe_out, // write beat taken
   output logic [1:0] beat_bank_out, // bank of current beat
   output logic [`SDCC_COL_W-1:0] beat_col_out, // column of current beat
   output logic [`SDCC_BANKS-1:0] bank_open_out, // banks with an open row
   output logic power_down_out, // in power-down
   output logic self_refresh_out // in self refresh
);
   sdcc_pkg::sdcc_pins_t pin_meta_ff;
   sdcc_pkg::sdcc_pins_t pin_ff;
   logic cke_meta_ff;
   logic cke_ff;
   logic cke_prev_ff;
   logic clk_en;
   logic act;
   sdcc_pkg::sdcc_cmd_t cmd;
   sdcc_pkg::sdcc_mode_t mode_ff;
   logic [`SDCC_ADDR_W-1:0] mode_reg_ff;
   logic ctrl_en_ff;
   logic [15:0] ref_cnt_ff;
   logic [`SDCC_BANKS-1:0] bank_open_ff;
   logic [`SDCC_ADDR_W-1:0] bank_row_ff [`SDCC_BANKS];
   logic burst_active_ff;
   logic burst_write_ff;
   logic burst_ap_ff;
   logic [1:0] burst_bank_ff;
   logic [`SDCC_COL_W-1:0] burst_start_ff;
   logic [`SDCC_COL_W-1:0] burst_cnt_ff;
   logic [`SDCC_COL_W-1:0] len_mask;
   logic [`SDCC_COL_W-1:0] col_offs;
   logic [`SDCC_COL_W-1:0] cur_col;
   logic full_page;
   logic cl3;
   logic beat;
   logic beat_last;
   logic rd_sr_ff;
   logic [`SDCC_COL_W+1:0] rd_pos_sr_ff;
   logic waitreq_ff;
   logic [31:0] rd_mux;

   // two flops per pin; the hold while powered down stands for gated input buffers
   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         pin_meta_ff <= '1;
         pin_ff <= '1;
         cke_meta_ff <= 1'b0;
         cke_ff <= 1'b0;
         cke_prev_ff <= 1'b0;
      end else begin
         pin_meta_ff <= '{cs_n: cs_n_in, ras_n: ras_n_in, cas_n: cas_n_in, we_n: we_n_in,
                          bank: {bank_sel_1_in, bank_sel_0_in}, addr: addr_in};
         if (mode_ff == sdcc_pkg::ST_ACTIVE) begin
            pin_ff <= pin_meta_ff;
         end
         cke_meta_ff <= cke_in;
         cke_ff <= cke_meta_ff;
         cke_prev_ff <= cke_ff;
      end
   end

   // enable seen at the previous edge gates this one, so a low enable suspends from the next cycle
   assign clk_en = cke_prev_ff;
   assign act = clk_en && (mode_ff == sdcc_pkg::ST_ACTIVE) && ctrl_en_ff;

   always_comb begin
      cmd = sdcc_pkg::CMD_NOP;
      if (!pin_ff.cs_n) begin
         case ({pin_ff.ras_n, pin_ff.cas_n, pin_ff.we_n})
            3'h3: cmd = sdcc_pkg::CMD_ACT;
            3'h2: cmd = sdcc_pkg::CMD_PRE;
            3'h5: cmd = sdcc_pkg::CMD_RD;
            3'h4: cmd = sdcc_pkg::CMD_WR;
            3'h6: cmd = sdcc_pkg::CMD_BST;
            3'h1: cmd = sdcc_pkg::CMD_REF;
            3'h0: cmd = sdcc_pkg::CMD_MRS;
            default: cmd = sdcc_pkg::CMD_NOP;
         endcase
      end
   end

   // burst length as a wrap mask over the low column bits
   always_comb begin
      case (mode_reg_ff[`SDCC_MR_BL_MSB:`SDCC_MR_BL_LSB])
         `SDCC_BL_1: len_mask = 8'h00;
         `SDCC_BL_2: len_mask = 8'h01;
         `SDCC_BL_4: len_mask = 8'h03;
         `SDCC_BL_8: len_mask = 8'h07;
         `SDCC_BL_PAGE: len_mask = 8'hFF;
         default: len_mask = 8'h00;
      endcase
   end

   assign full_page = (mode_reg_ff[`SDCC_MR_BL_MSB:`SDCC_MR_BL_LSB] == `SDCC_BL_PAGE);
   assign cl3 = (mode_reg_ff[`SDCC_MR_CL_MSB:`SDCC_MR_CL_LSB] == `SDCC_CL_3);
   // interleave is undefined for a full page, which stays linear
   assign col_offs = (mode_reg_ff[`SDCC_MR_BT_BIT] && !full_page) ?
                     (burst_start_ff ^ burst_cnt_ff) : (burst_start_ff + burst_cnt_ff);
   assign cur_col = (burst_start_ff & ~len_mask) | (col_offs & len_mask);
   assign beat = burst_active_ff && clk_en;
   // a full page burst wraps until stopped
   assign beat_last = !full_page && (burst_cnt_ff == len_mask);

   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         mode_reg_ff <= `SDCC_MR_RST;
         ref_cnt_ff <= 16'h0000;
      end else if (act && (cmd == sdcc_pkg::CMD_MRS)) begin
         mode_reg_ff <= pin_ff.addr;
      end else if (act && (cmd == sdcc_pkg::CMD_REF) && cke_ff) begin
         ref_cnt_ff <= ref_cnt_ff + 16'h0001;
      end
   end

   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         bank_open_ff <= '0;
         for (int i = 0; i < `SDCC_BANKS; i++) begin
            bank_row_ff[i] <= '0;
         end
      end else begin
         if (beat && beat_last && burst_ap_ff) begin
            bank_open_ff[burst_bank_ff] <= 1'b0;
         end
         if (act && (cmd == sdcc_pkg::CMD_ACT) && !bank_open_ff[pin_ff.bank]) begin
            bank_open_ff[pin_ff.bank] <= 1'b1;
            bank_row_ff[pin_ff.bank] <= pin_ff.addr;
         end
         if (act && (cmd == sdcc_pkg::CMD_PRE)) begin
            if (pin_ff.addr[`SDCC_AP_BIT]) begin
               bank_open_ff <= '0;
            end else begin
               bank_open_ff[pin_ff.bank] <= 1'b0;
            end
         end
      end
   end

   // a read or write to a closed bank is dropped; the controller must open it first
   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         burst_active_ff <= 1'b0;
         burst_write_ff <= 1'b0;
         burst_ap_ff <= 1'b0;
         burst_bank_ff <= 2'h0;
         burst_start_ff <= 8'h00;
         burst_cnt_ff <= 8'h00;
      end else if (act && ((cmd == sdcc_pkg::CMD_RD) || (cmd == sdcc_pkg::CMD_WR)) &&
                   bank_open_ff[pin_ff.bank]) begin
         burst_active_ff <= 1'b1;
         burst_write_ff <= (cmd == sdcc_pkg::CMD_WR);
         burst_ap_ff <= pin_ff.addr[`SDCC_AP_BIT];
         burst_bank_ff <= pin_ff.bank;
         burst_start_ff <= pin_ff.addr[`SDCC_COL_W-1:0];
         burst_cnt_ff <= 8'h00;
      end else if (act && (cmd == sdcc_pkg::CMD_BST)) begin
         burst_active_ff <= 1'b0;
      end else if (beat) begin
         burst_cnt_ff <= burst_cnt_ff + 8'h01;
         if (beat_last) begin
            burst_active_ff <= 1'b0;
         end
      end
   end

   // everything here holds while the clock is suspended
   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         rd_sr_ff <= 1'b0;
         rd_pos_sr_ff <= '0;
         rd_strobe_out <= 1'b0;
         wr_strobe_out <= 1'b0;
         beat_bank_out <= 2'h0;
         beat_col_out <= 8'h00;
      end else if (clk_en) begin
         rd_sr_ff <= beat && !burst_write_ff;
         rd_pos_sr_ff <= {burst_bank_ff, cur_col};
         rd_strobe_out <= cl3 ? rd_sr_ff : (beat && !burst_write_ff);
         wr_strobe_out <= beat && burst_write_ff;
         if ((beat && burst_write_ff) || !cl3) begin
            {beat_bank_out, beat_col_out} <= {burst_bank_ff, cur_col};
         end else begin
            {beat_bank_out, beat_col_out} <= rd_pos_sr_ff;
         end
      end
   end

   // one clock only, so leaving power-down costs the sync delay, not an extra command edge
   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         mode_ff <= sdcc_pkg::ST_ACTIVE;
      end else begin
         case (mode_ff)
            sdcc_pkg::ST_ACTIVE: begin
               if (cke_prev_ff && !cke_ff && (bank_open_ff == '0) && !burst_active_ff) begin
                  mode_ff <= (cmd == sdcc_pkg::CMD_REF) ? sdcc_pkg::ST_SELF_REFRESH : sdcc_pkg::ST_POWER_DOWN;
               end
            end
            sdcc_pkg::ST_POWER_DOWN, sdcc_pkg::ST_SELF_REFRESH: begin
               if (cke_ff) begin
                  mode_ff <= sdcc_pkg::ST_ACTIVE;
               end
            end
            default: begin
               mode_ff <= sdcc_pkg::ST_ACTIVE;
            end
         endcase
      end
   end

   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         bank_open_out <= '0;
         power_down_out <= 1'b0;
         self_refresh_out <= 1'b0;
      end else begin
         bank_open_out <= bank_open_ff;
         power_down_out <= (mode_ff == sdcc_pkg::ST_POWER_DOWN);
         self_refresh_out <= (mode_ff == sdcc_pkg::ST_SELF_REFRESH);
      end
   end

   always_comb begin
      rd_mux = 32'h00000000;
      case (avs_address_in)
         `SDCC_REG_CTRL: rd_mux[`SDCC_CTRL_EN_BIT] = ctrl_en_ff;
         `SDCC_REG_STATUS: begin
            rd_mux[`SDCC_BANKS-1:0] = bank_open_ff;
            rd_mux[`SDCC_ST_BURST_BIT] = burst_active_ff;
            rd_mux[`SDCC_ST_WRITE_BIT] = burst_write_ff;
            rd_mux[`SDCC_ST_MODE_LSB+1:`SDCC_ST_MODE_LSB] = mode_ff;
         end
         `SDCC_REG_MODE: rd_mux[`SDCC_ADDR_W-1:0] = mode_reg_ff;
         `SDCC_REG_REFCNT: rd_mux[15:0] = ref_cnt_ff;
         default: rd_mux = 32'h00000000;
      endcase
   end

   // fixed one wait cycle, then the answer edge; unmapped reads give zero
   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         waitreq_ff <= 1'b1;
         avs_readdata_out <= 32'h00000000;
      end else if ((avs_read_in || avs_write_in) && waitreq_ff) begin
         waitreq_ff <= 1'b0;
         avs_readdata_out <= avs_read_in ? rd_mux : 32'h00000000;
      end else begin
         waitreq_ff <= 1'b1;
      end
   end
   assign avs_waitrequest_out = waitreq_ff;

   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         ctrl_en_ff <= `SDCC_CTRL_RST;
      end else if (avs_write_in && !waitreq_ff && (avs_address_in == `SDCC_REG_CTRL) && avs_byteenable_in[0]) begin
         ctrl_en_ff <= avs_writedata_in[`SDCC_CTRL_EN_BIT];
      end
   end

   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!nrst_in);

   AST_CS_MASK: assert property (act && pin_ff.cs_n && !burst_active_ff |=> $stable(bank_open_ff))
      else $error("command decoded with chip select high");
   AST_ACT_OPENS: assert property (act && cmd == sdcc_pkg::CMD_ACT && !bank_open_ff[pin_ff.bank]
      |=> bank_open_ff[$past(pin_ff.bank)] && bank_row_ff[$past(pin_ff.bank)] == $past(pin_ff.addr))
      else $error("row open did not take");
   AST_PRE_ALL: assert property (act && cmd == sdcc_pkg::CMD_PRE && pin_ff.addr[`SDCC_AP_BIT] |=> bank_open_ff == '0)
      else $error("precharge all left a bank open");
   AST_CL2: assert property (beat && !burst_write_ff && !cl3 |=> rd_strobe_out)
      else $error("read strobe missing at latency two");
   AST_CL3: assert property (beat && !burst_write_ff && cl3 ##1 clk_en |=> rd_strobe_out)
      else $error("read strobe missing at latency three");
   AST_FREEZE: assert property (!clk_en |=> $stable(burst_cnt_ff) && $stable(rd_strobe_out))
      else $error("state moved while clock suspended");
   AST_BL1: assert property (beat && len_mask == 8'h00 && !act |=> !burst_active_ff)
      else $error("single beat burst did not end");
   AST_BST: assert property (act && cmd == sdcc_pkg::CMD_BST |=> !burst_active_ff)
      else $error("burst stop ignored");
   AST_AP: assert property (beat && beat_last && burst_ap_ff && !act |=> !bank_open_ff[$past(burst_bank_ff)])
      else $error("auto precharge left row open");
   AST_PD_IDLE: assert property (mode_ff == sdcc_pkg::ST_ACTIVE ##1 mode_ff != sdcc_pkg::ST_ACTIVE
      |-> $past(bank_open_ff) == '0)
      else $error("power-down entered with a bank open");
   AST_PD_EXIT: assert property (mode_ff != sdcc_pkg::ST_ACTIVE && cke_ff |=> mode_ff == sdcc_pkg::ST_ACTIVE)
      else $error("power-down not left on clock enable");
   AST_PD_HOLD: assert property (mode_ff != sdcc_pkg::ST_ACTIVE |=> $stable(pin_ff))
      else $error("inputs moved while powered down");
endmodule

// ===== rtl/sdcc_consts.svh
// constants for the sdram command and clock interface block
`ifndef SDCC_CONSTS_SVH
`define SDCC_CONSTS_SVH
`define SDCC_ADDR_W 12
`define SDCC_COL_W 8
`define SDCC_BANKS 4
`define SDCC_AP_BIT 10
`define SDCC_MR_BL_MSB 2
`define SDCC_MR_BL_LSB 0
`define SDCC_MR_BT_BIT 3
`define SDCC_MR_CL_MSB 6
`define SDCC_MR_CL_LSB 4
`define SDCC_BL_1 3'h0
`define SDCC_BL_2 3'h1
`define SDCC_BL_4 3'h2
`define SDCC_BL_8 3'h3
`define SDCC_BL_PAGE 3'h7
`define SDCC_CL_3 3'h3
`define SDCC_MR_RST 12'h020
`define SDCC_REG_CTRL 4'h0
`define SDCC_REG_STATUS 4'h4
`define SDCC_REG_MODE 4'h8
`define SDCC_REG_REFCNT 4'hC
`define SDCC_CTRL_EN_BIT 0
`define SDCC_CTRL_RST 1'h1
`define SDCC_ST_BURST_BIT 4
`define SDCC_ST_WRITE_BIT 5
`define SDCC_ST_MODE_LSB 8
`endif

// ===== rtl/sdcc_pkg.sv
// types shared by the sdram command and clock interface block
`include "sdcc_consts.svh"
package sdcc_pkg;
   typedef struct packed {
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic [1:0] bank;
      logic [`SDCC_ADDR_W-1:0] addr;
   } sdcc_pins_t;
   typedef enum logic [2:0] {
      CMD_NOP, CMD_ACT, CMD_PRE, CMD_RD, CMD_WR, CMD_BST, CMD_REF, CMD_MRS
   } sdcc_cmd_t;
   typedef enum logic [1:0] {
      ST_ACTIVE, ST_POWER_DOWN, ST_SELF_REFRESH
   } sdcc_mode_t;
endpackage

// ===== test/sdcc_ctl_model.sv
// controller-side model that drives the sdram command pins
`timescale 1ns/10ps
module sdcc_ctl_model (
   input wire logic clock_in, // system clock
   output sdcc_pkg::sdcc_pins_t pins_out // command pins
);
   initial pins_out = '{1'b1, 1'b1, 1'b1, 1'b1, 2'h0, 12'h000};
   // one command for one cycle, then nop with inverted address so stale values never look valid
   task automatic issue(input sdcc_pkg::sdcc_cmd_t c, input logic [1:0] b, input logic [11:0] a,
                        input logic sel_n, output time t);
      logic [2:0] code;
      case (c)
         sdcc_pkg::CMD_ACT: code = 3'h3;
         sdcc_pkg::CMD_PRE: code = 3'h2;
         sdcc_pkg::CMD_RD: code = 3'h5;
         sdcc_pkg::CMD_WR: code = 3'h4;
         sdcc_pkg::CMD_BST: code = 3'h6;
         sdcc_pkg::CMD_REF: code = 3'h1;
         sdcc_pkg::CMD_MRS: code = 3'h0;
         default: code = 3'h7;
      endcase
      @(posedge clock_in);
      pins_out <= '{sel_n, code[2], code[1], code[0], b, a};
      t = $time;
      @(posedge clock_in);
      pins_out <= '{1'b0, 1'b1, 1'b1, 1'b1, ~b, ~a};
   endtask
endmodule

// ===== test/tb.sv
// self-checking bench for the sdram command and clock interface
`timescale 1ns/10ps
module tb;
   logic clock_in = 1'b0;
   logic nrst_in = 1'b0;
   logic cke_in = 1'b1;
   logic [3:0] avs_address_in = 4'h0;
   logic avs_read_in = 1'b0;
   logic avs_write_in = 1'b0;
   logic [31:0] avs_writedata_in = 32'h0;
   logic [3:0] avs_byteenable_in = 4'hF;
   logic [31:0] avs_readdata_out, q;
   logic avs_waitrequest_out, rd_strobe_out, wr_strobe_out, power_down_out, self_refresh_out;
   logic [1:0] beat_bank_out;
   logic [7:0] beat_col_out;
   logic [3:0] bank_open_out;
   sdcc_pkg::sdcc_pins_t pins;
   int err_total = 0;
   int n_tests = 0;
   int wcnt = 0;
   int w0 = 0;
   logic [3:0] cke_seen = 4'hF;
   time t, t2;
   time rt[$];
   logic [9:0] rc[$];
   always #12.5 clock_in = ~clock_in;
   sdcc_ctl_model ctl (.clock_in(clock_in), .pins_out(pins));
   sdcc_core DUT (.clock_in(clock_in), .nrst_in(nrst_in), .cke_in(cke_in), .cs_n_in(pins.cs_n),
      .ras_n_in(pins.ras_n), .cas_n_in(pins.cas_n), .we_n_in(pins.we_n), .bank_sel_0_in(pins.bank[0]),
      .bank_sel_1_in(pins.bank[1]), .addr_in(pins.addr), .avs_address_in(avs_address_in),
      .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
      .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
      .avs_waitrequest_out(avs_waitrequest_out), .rd_strobe_out(rd_strobe_out),
      .wr_strobe_out(wr_strobe_out), .beat_bank_out(beat_bank_out), .beat_col_out(beat_col_out),
      .bank_open_out(bank_open_out), .power_down_out(power_down_out),
      .self_refresh_out(self_refresh_out));
   // controller side capture of beats; cke gates the core three edges late and the strobes four,
   // and a strobe held through a suspended cycle is the same beat again
   always @(posedge clock_in) begin
      cke_seen <= {cke_seen[2:0], cke_in};
      if (rd_strobe_out === 1'b1 && cke_seen[3]) begin
         rt.push_back($time);
         rc.push_back({beat_bank_out, beat_col_out});
      end
      if (wr_strobe_out === 1'b1 && cke_seen[3]) wcnt++;
   end
   task automatic stop_test();
      $display("mismatches %0d comparisons %0d", err_total, n_tests);
      if (err_total == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_tests++;
      if (got !== exp) begin
         $display("CHECK FAILED %0t %s got %0h exp %0h", $time, m, got, exp);
         err_total++;
      end
   endtask
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
      int n;
      @(posedge clock_in);
      avs_address_in <= a;
      avs_writedata_in <= d;
      avs_write_in <= wr;
      avs_read_in <= ~wr;
      for (n = 0; n < 20; n++) begin
         @(posedge clock_in);
         if (avs_waitrequest_out === 1'b0) break;
      end
      r = avs_readdata_out;
      avs_read_in <= 1'b0;
      avs_write_in <= 1'b0;
      if (n == 20) begin
         err_total++;
         stop_test();
      end
   endtask
   task automatic waitv(input logic sr, input logic v, input string m);
      int n;
      for (n = 0; n < 40 && (sr ? self_refresh_out : power_down_out) !== v; n++) @(posedge clock_in);
      chk(32'(sr ? self_refresh_out : power_down_out), 32'(v), m);
      if (n == 40) stop_test();
   endtask
   task automatic mode(input logic [11:0] op);
      ctl.issue(sdcc_pkg::CMD_MRS, 2'h0, op, 1'b0, t);
      repeat (6) @(posedge clock_in);
      rt.delete();
      rc.delete();
   endtask
   // expected column order built from start, length and type
   task automatic burst(input int k, input logic bt, input int cl, input logic [1:0] b, input logic [7:0] s);
      int n;
      logic [7:0] c;
      n = 1 << k;
      mode({5'h00, cl[2:0], bt, k[2:0]});
      ctl.issue(sdcc_pkg::CMD_RD, b, {4'h0, s}, 1'b0, t);
      repeat (20) @(posedge clock_in);
      chk(32'(rt.size()), 32'(n), "read beat count");
      for (int i = 0; i < n; i++) begin
         c = 8'((s & ~(n - 1)) | (bt ? ((s % n) ^ i) : ((s % n + i) % n)));
         chk(32'(rc[i]), {22'h0, b, c}, "beat bank and column");
         chk(32'(rt[i] - t), 32'((5 + (cl == 3) + i) * 25), "beat timing");
      end
   endtask
   initial begin
      q = 32'($urandom(32'h2840c948));
      repeat (6) @(posedge clock_in);
      chk(32'(avs_waitrequest_out), 32'h1, "waitrequest in reset");
      chk(32'(bank_open_out), 32'h0, "banks in reset");
      nrst_in <= 1'b1;
      bus(1'b0, 4'h8, 32'h0, q);
      chk(q, 32'h020, "mode reset value");
      bus(1'b0, 4'h0, 32'h0, q);
      chk(q, 32'h1, "ctrl reset value");
      bus(1'b0, 4'h2, 32'h0, q);
      chk(q, 32'h0, "unmapped read");
      ctl.issue(sdcc_pkg::CMD_ACT, 2'h0, 12'h123, 1'b1, t);
      repeat (8) @(posedge clock_in);
      chk(32'(bank_open_out), 32'h0, "deselected open");
      for (int b = 0; b < 4; b++) begin
         ctl.issue(sdcc_pkg::CMD_ACT, 2'(b), 12'(b * 100), 1'b0, t);
         repeat (5) @(posedge clock_in);
         chk(32'(bank_open_out), 32'((2 << b) - 1), "bank open");
      end
      bus(1'b0, 4'h4, 32'h0, q);
      chk(q & 32'hF, 32'hF, "status open banks");
      for (int cl = 2; cl < 4; cl++)
         for (int bt = 0; bt < 2; bt++)
            for (int k = 0; k < 4; k++)
               burst(k, bt[0], cl, 2'($urandom), 8'($urandom));
      mode(12'h022);
      w0 = wcnt;
      ctl.issue(sdcc_pkg::CMD_WR, 2'h2, {4'h4, 8'($urandom)}, 1'b0, t);
      repeat (20) @(posedge clock_in);
      chk(32'(wcnt - w0), 32'h4, "write beats");
      chk(32'(bank_open_out), 32'hB, "auto precharge");
      mode(12'h027);
      ctl.issue(sdcc_pkg::CMD_RD, 2'h1, {4'h0, 8'($urandom)}, 1'b0, t);
      repeat (3) @(posedge clock_in);
      ctl.issue(sdcc_pkg::CMD_BST, 2'h1, 12'h000, 1'b0, t2);
      repeat (30) @(posedge clock_in);
      q = 32'((t2 - t) / 25);
      chk(32'(rt.size() == q || rt.size() == q + 1), 32'h1, "burst stop count");
      mode(12'h023);
      ctl.issue(sdcc_pkg::CMD_RD, 2'h1, 12'h000, 1'b0, t);
      cke_in <= 1'b0;
      repeat (3) @(posedge clock_in);
      cke_in <= 1'b1;
      repeat (30) @(posedge clock_in);
      chk(32'(rt.size()), 32'h8, "suspended burst count");
      // three low samples of cke stretch the burst by three cycles
      chk(32'(rt[7] - t), 32'((5 + 7 + 3) * 25), "burst frozen while suspended");
      cke_in <= 1'b0;
      repeat (8) @(posedge clock_in);
      chk(32'(power_down_out), 32'h0, "suspend with open banks");
      cke_in <= 1'b1;
      ctl.issue(sdcc_pkg::CMD_PRE, 2'h3, 12'h000, 1'b0, t);
      repeat (5) @(posedge clock_in);
      chk(32'(bank_open_out), 32'h3, "single precharge");
      ctl.issue(sdcc_pkg::CMD_PRE, 2'h0, 12'h400, 1'b0, t);
      repeat (5) @(posedge clock_in);
      chk(32'(bank_open_out), 32'h0, "precharge all");
      ctl.issue(sdcc_pkg::CMD_REF, 2'h0, 12'h000, 1'b0, t);
      repeat (6) @(posedge clock_in);
      bus(1'b0, 4'hC, 32'h0, q);
      chk(q, 32'h1, "refresh count");
      cke_in <= 1'b0;
      waitv(1'b0, 1'b1, "power-down entry");
      bus(1'b0, 4'h4, 32'h0, q);
      chk(q, 32'h100, "status in power-down");
      ctl.issue(sdcc_pkg::CMD_ACT, 2'h0, 12'h000, 1'b0, t);
      cke_in <= 1'b1;
      waitv(1'b0, 1'b0, "power-down exit");
      repeat (6) @(posedge clock_in);
      chk(32'(bank_open_out), 32'h0, "pins ignored in power-down");
      fork
         ctl.issue(sdcc_pkg::CMD_REF, 2'h0, 12'h000, 1'b0, t);
         @(posedge clock_in) cke_in <= 1'b0;
      join
      waitv(1'b1, 1'b1, "self refresh entry");
      cke_in <= 1'b1;
      waitv(1'b1, 1'b0, "self refresh exit");
      avs_byteenable_in <= 4'hE;
      bus(1'b1, 4'h0, 32'h0, q);
      bus(1'b0, 4'h0, 32'h0, q);
      chk(q, 32'h1, "ctrl write without lane 0");
      avs_byteenable_in <= 4'hF;
      bus(1'b1, 4'h0, 32'h0, q);
      ctl.issue(sdcc_pkg::CMD_ACT, 2'h2, 12'h000, 1'b0, t);
      repeat (6) @(posedge clock_in);
      chk(32'(bank_open_out), 32'h0, "decode disabled");
      bus(1'b1, 4'h0, 32'h1, q);
      stop_test();
   end
endmodule
